/* src/iosad_decoder.sv */
// Purpose: I/O space decoder with three general purpose stores and one status flag register.
// Assumes: The core holds a request for one cycle with op_valid_in; addresses are data-space
//          addresses for load/store and I/O addresses for in/out and bit operations.
// Notes:   Peripheral strobes are decoded in the request cycle; answers appear one cycle later.
`timescale 1ns/1ns
module iosad_decoder #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  srst_in,
  // Core request
  input  wire logic                  op_valid_in,
  input  wire iosad_pkg::iosad_op_t  op_kind_in,
  input  wire logic [ADDR_W-1:0]     addr_in,
  input  wire logic [7:0]            wdata_in,
  input  wire logic [2:0]            bit_sel_in,
  // Core answer
  output logic                       ack_out,
  output logic                       fault_out,
  output logic [7:0]                 rdata_out,
  output logic                       skip_out,
  // Peripheral register port
  output logic                       per_sel_out,
  output logic                       per_we_out,
  output logic [ADDR_W-1:0]          per_addr_out,
  output logic [7:0]                 per_wdata_out,
  output logic [7:0]                 per_wmask_out,
  input  wire logic [7:0]            per_rdata_in,
  // Status flags
  input  wire logic [7:0]            flag_set_in,
  output logic [7:0]                 flags_out
);

  // Register offsets reach 0xFF, so an address narrower than a byte cannot decode the space.
  if (ADDR_W < 8)
  begin : g_addr_w_check
    $error("ADDR_W must be at least 8");
  end

  logic [7:0] gp0;
  logic [7:0] gp1;
  logic [7:0] gp2;

  wire logic [ADDR_W-1:0] offset_w    = ADDR_W'(iosad_pkg::DATA_OFFSET);
  wire logic [ADDR_W-1:0] direct_last = ADDR_W'(iosad_pkg::IO_DIRECT_LAST);
  wire logic [ADDR_W-1:0] bit_last    = ADDR_W'(iosad_pkg::IO_BIT_LAST);
  wire logic [ADDR_W-1:0] ext_last    = ADDR_W'(iosad_pkg::EXT_LAST);

  wire logic is_inout   = (op_kind_in == iosad_pkg::OP_IN) || (op_kind_in == iosad_pkg::OP_OUT);
  wire logic is_setbit  = (op_kind_in == iosad_pkg::OP_SETBIT);
  wire logic is_clrbit  = (op_kind_in == iosad_pkg::OP_CLRBIT);
  wire logic is_skipset = (op_kind_in == iosad_pkg::OP_SKIPSET);
  wire logic is_skipclr = (op_kind_in == iosad_pkg::OP_SKIPCLR);
  wire logic is_bitop   = is_setbit || is_clrbit || is_skipset || is_skipclr;
  wire logic is_ldst    = (op_kind_in == iosad_pkg::OP_LOAD)
                          || (op_kind_in == iosad_pkg::OP_STORE);
  wire logic is_write   = (op_kind_in == iosad_pkg::OP_OUT) || (op_kind_in == iosad_pkg::OP_STORE)
                          || is_setbit || is_clrbit;

  // Short-address operations are shifted into data space; load and store use it directly.
  // The carry is dropped on purpose; a wrapped short address is refused by too_high anyway.
  wire logic [ADDR_W-1:0] data_addr = is_ldst ? addr_in : ADDR_W'(addr_in + offset_w);

  // The in/out field spans 64 locations and bit operations 32; anything above is refused.
  wire logic too_high = (is_inout && (addr_in > direct_last))
                        || (is_bitop && (addr_in > bit_last));
  wire logic in_space = (data_addr >= offset_w) && (data_addr <= ext_last);
  wire logic take     = op_valid_in && !too_high && in_space;
  wire logic wr       = take && is_write;

  wire logic [7:0] bit_mask = iosad_pkg::BIT_ONE << bit_sel_in;
  wire logic [7:0] wmask    = (is_setbit || is_clrbit) ? bit_mask : iosad_pkg::MASK_ALL;
  wire logic [7:0] wval     = is_setbit ? bit_mask :
                              is_clrbit ? iosad_pkg::MASK_NONE : wdata_in;

  wire logic sel_flags = take && (data_addr == ADDR_W'(iosad_pkg::FLAGS_ADDR));
  wire logic sel_gp0   = take && (data_addr == ADDR_W'(iosad_pkg::GP0_ADDR));
  wire logic sel_gp1   = take && (data_addr == ADDR_W'(iosad_pkg::GP1_ADDR));
  wire logic sel_gp2   = take && (data_addr == ADDR_W'(iosad_pkg::GP2_ADDR));
  wire logic sel_int   = sel_flags || sel_gp0 || sel_gp1 || sel_gp2;

  wire logic [7:0] rd_value = sel_flags ? flags_out :
                              sel_gp0   ? gp0 :
                              sel_gp1   ? gp1 :
                              sel_gp2   ? gp2 : per_rdata_in;
  wire logic bit_value = |(rd_value & bit_mask);
  wire logic next_skip = take && ((is_skipset && bit_value) || (is_skipclr && !bit_value));

  // Peripheral strobes are combinational so a read completes in one cycle.
  assign per_sel_out   = take && !sel_int;
  assign per_we_out    = per_sel_out && is_write;
  assign per_addr_out  = data_addr;
  assign per_wdata_out = wval;
  assign per_wmask_out = wmask;

  iosad_reg8 #(
    .CLEAR_ON_ONE (1'b1),
    .RESET_VALUE  (iosad_pkg::FLAGS_RESET)
  ) u_flags (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .wr_in     (wr && sel_flags),
    .mask_in   (wmask),
    .wdata_in  (wval),
    .hw_set_in (flag_set_in),
    .q_out     (flags_out)
  );

  iosad_reg8 #(
    .CLEAR_ON_ONE (1'b0),
    .RESET_VALUE  (iosad_pkg::GP_RESET)
  ) u_gp0 (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .wr_in     (wr && sel_gp0),
    .mask_in   (wmask),
    .wdata_in  (wval),
    .hw_set_in (iosad_pkg::MASK_NONE),
    .q_out     (gp0)
  );

  iosad_reg8 #(
    .CLEAR_ON_ONE (1'b0),
    .RESET_VALUE  (iosad_pkg::GP_RESET)
  ) u_gp1 (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .wr_in     (wr && sel_gp1),
    .mask_in   (wmask),
    .wdata_in  (wval),
    .hw_set_in (iosad_pkg::MASK_NONE),
    .q_out     (gp1)
  );

  iosad_reg8 #(
    .CLEAR_ON_ONE (1'b0),
    .RESET_VALUE  (iosad_pkg::GP_RESET)
  ) u_gp2 (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .wr_in     (wr && sel_gp2),
    .mask_in   (wmask),
    .wdata_in  (wval),
    .hw_set_in (iosad_pkg::MASK_NONE),
    .q_out     (gp2)
  );

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      ack_out   <= 1'b0;
      fault_out <= 1'b0;
      rdata_out <= 8'h00;
      skip_out  <= 1'b0;
    end
    else
    begin
      ack_out   <= op_valid_in;
      fault_out <= op_valid_in && !take;
      rdata_out <= take ? rd_value : 8'h00;
      skip_out  <= next_skip;
    end
  end

  // Helpers read only by the checks below.
  wire logic [7:0] flag_clear = wr && sel_flags ? (wmask & wval & ~flag_set_in) : 8'h00;
  wire logic       gp0_bit    = |(gp0 & bit_mask);
  wire logic       gp1_store  = wr && sel_gp1 && (op_kind_in == iosad_pkg::OP_STORE);
  wire logic       gp2_load   = take && sel_gp2 && (op_kind_in == iosad_pkg::OP_LOAD);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  sequence s_bit_refused;
    op_valid_in && is_bitop && (addr_in > bit_last);
  endsequence
  sequence s_refused_answer;
    ack_out && fault_out && !skip_out;
  endsequence

  a_bitop_range_refused: assert property (
    s_bit_refused |-> !per_sel_out ##1 s_refused_answer)
    else $error("bit operation above 0x1F was not refused");
  a_inout_range_refused: assert property (
    op_valid_in && is_inout && (addr_in > direct_last) |-> !per_we_out ##1 fault_out)
    else $error("in/out above 0x3F was not refused");
  a_io_offset_map: assert property (
    per_sel_out && !is_ldst |-> per_addr_out == addr_in + ADDR_W'(iosad_pkg::DATA_OFFSET))
    else $error("short address not offset by 0x20");
  a_ext_ldst_only: assert property (
    per_sel_out && (per_addr_out >= ADDR_W'(iosad_pkg::EXT_FIRST)) |-> is_ldst)
    else $error("extended register reached by a short operation");
  a_bitop_one_bit: assert property (
    per_we_out && (is_setbit || is_clrbit) |-> $onehot(per_wmask_out))
    else $error("bit operation wrote more than one bit");
  a_flag_clear_one: assert property (
    flag_clear != 8'h00 |=> (flags_out & $past(flag_clear)) == 8'h00)
    else $error("status flag not cleared by writing one");
  a_skip_tests_bit: assert property (
    take && is_skipset && sel_gp0 |=> skip_out == $past(gp0_bit))
    else $error("skip result does not match tested bit");
  a_gp1_store_holds: assert property (
    gp1_store |=> gp1 == $past(wdata_in) ##1 (ack_out || $stable(gp1)))
    else $error("store to general purpose store one lost");
  a_gp2_load_reads: assert property (gp2_load |=> ack_out && rdata_out == $past(gp2))
    else $error("load of general purpose store two returned wrong value");
  a_gp0_no_side: assert property (!(wr && sel_gp0) |=> $stable(gp0))
    else $error("general purpose store zero changed without a write");

endmodule // iosad_decoder

/* src/iosad_pkg.sv */
// Purpose: Shared constants and types of the I/O space access decoder.
// Assumes: Data-space addresses are 16 bits wide; register data is 8 bits wide.
// Notes:   Internal register addresses are data-space addresses (I/O address plus offset).
package iosad_pkg;

  // Core operation kinds presented on the request port.
  typedef enum logic [2:0] {
    OP_IN      = 3'b000,
    OP_OUT     = 3'b001,
    OP_SETBIT  = 3'b010,
    OP_CLRBIT  = 3'b011,
    OP_SKIPSET = 3'b100,
    OP_SKIPCLR = 3'b101,
    OP_LOAD    = 3'b110,
    OP_STORE   = 3'b111
  } iosad_op_t;

  // Address map of the I/O space.
  localparam logic [15:0] DATA_OFFSET    = 16'h0020;
  localparam logic [15:0] IO_DIRECT_LAST = 16'h003F;
  localparam logic [15:0] IO_BIT_LAST    = 16'h001F;
  localparam logic [15:0] EXT_FIRST      = 16'h0060;
  localparam logic [15:0] EXT_LAST       = 16'h00FF;

  // Data-space addresses of the registers held inside this block.
  localparam logic [15:0] FLAGS_ADDR = 16'h003C;
  localparam logic [15:0] GP0_ADDR   = 16'h003E;
  localparam logic [15:0] GP1_ADDR   = 16'h004A;
  localparam logic [15:0] GP2_ADDR   = 16'h004B;

  // Reset values.
  localparam logic [7:0] GP_RESET    = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Byte-wide masks.
  localparam logic [7:0] MASK_ALL  = 8'hFF;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] BIT_ONE   = 8'h01;

endpackage

/* src/iosad_reg8.sv */
// Purpose: One 8-bit register with per-bit write mask, plain or clear-on-one.
// Assumes: Hardware set inputs are single-cycle or level events on clk_in.
// Notes:   In clear-on-one mode a hardware set in the clearing cycle wins.
`timescale 1ns/1ns
module iosad_reg8 #(
  parameter bit         CLEAR_ON_ONE = 1'b0,
  parameter logic [7:0] RESET_VALUE  = 8'h00
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  // Write port
  input  wire logic       wr_in,
  input  wire logic [7:0] mask_in,
  input  wire logic [7:0] wdata_in,
  // Hardware event set, used only in clear-on-one mode
  input  wire logic [7:0] hw_set_in,
  // Stored value
  output logic      [7:0] q_out
);

  logic [7:0] next_q;
  wire  [7:0] hit_bits    = wr_in ? mask_in : 8'h00;
  wire  [7:0] clear_bits  = hit_bits & wdata_in;
  wire  [7:0] plain_value = (q_out & ~hit_bits) | (wdata_in & hit_bits);
  // Only masked bits see the write, so a single-bit operation never clears a neighbour.
  wire  [7:0] flag_value  = (q_out & ~clear_bits) | hw_set_in;

  assign next_q = CLEAR_ON_ONE ? flag_value : plain_value;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      q_out <= RESET_VALUE;
    else
      q_out <= next_q;
  end

endmodule // iosad_reg8

/* test/iosad_decoder_test.sv */
// Purpose: Self-checking bench for the I/O space access decoder.
// Assumes: One request at a time, driven on the falling edge.
// Notes:   Software never writes reserved places, and reserved bits are written as zero.
`timescale 1ns/1ns
module iosad_decoder_test;
  logic                 clk_in = 1'b0;
  logic                 srst_in = 1'b1;
  logic                 valid = 1'b0;
  iosad_pkg::iosad_op_t kind = iosad_pkg::OP_IN;
  logic [15:0]          addr = 16'h0000;
  logic [7:0]           wdata = 8'h00;
  logic [2:0]           bsel = 3'h0;
  logic [7:0]           flag_set = 8'h00;
  logic                 ack, fault, skip, psel, pwe;
  logic [7:0]           rdata, pwdata, pwmask, prdata, flags, rd;
  logic [15:0]          paddr;
  logic                 sk;
  logic                 ps;
  logic                 pw;
  logic [15:0]          pa;
  int                   n_errors = 0;
  int                   tests_run = 0;
  int                   cycles = 0;
  logic [7:0]           vals [3] = '{8'h5A, 8'hC3, 8'hFF};
  logic [15:0]          regs [3] = '{16'h003E, 16'h004A, 16'h004B};

  iosad_decoder iosad_decoder_inst (.clk_in(clk_in), .srst_in(srst_in), .op_valid_in(valid),
    .op_kind_in(kind), .addr_in(addr), .wdata_in(wdata), .bit_sel_in(bsel), .ack_out(ack),
    .fault_out(fault), .rdata_out(rdata), .skip_out(skip), .per_sel_out(psel),
    .per_we_out(pwe), .per_addr_out(paddr), .per_wdata_out(pwdata), .per_wmask_out(pwmask),
    .per_rdata_in(prdata), .flag_set_in(flag_set), .flags_out(flags));
  iosad_periph_model iosad_periph_model_inst (.clk_in(clk_in), .sel_in(psel), .we_in(pwe),
    .addr_in(paddr), .wdata_in(pwdata), .wmask_in(pwmask), .rdata_out(prdata));

  always #10 clk_in = ~clk_in;

  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // A hang would otherwise never reach the report.
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      $display("unexpected at %0t: timeout", $time);
      n_errors++;
      end_sim();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
      n_errors++;
    end
  endtask

  // One request cycle; peripheral strobes are sampled before the edge, the answer after it.
  task automatic op(input iosad_pkg::iosad_op_t k, input logic [15:0] a, input logic [7:0] d,
                    input logic [2:0] b, input logic f);
    logic [15:0] da;
    logic        in_reg;
    logic        wr_k;
    da = (k == iosad_pkg::OP_LOAD || k == iosad_pkg::OP_STORE) ? a : a + iosad_pkg::DATA_OFFSET;
    in_reg = (da == iosad_pkg::FLAGS_ADDR) || (da == iosad_pkg::GP0_ADDR)
             || (da == iosad_pkg::GP1_ADDR) || (da == iosad_pkg::GP2_ADDR);
    wr_k = (k == iosad_pkg::OP_OUT) || (k == iosad_pkg::OP_STORE)
           || (k == iosad_pkg::OP_SETBIT) || (k == iosad_pkg::OP_CLRBIT);
    @(negedge clk_in);
    valid = 1'b1;
    kind = k;
    addr = a;
    wdata = d;
    bsel = b;
    #5;
    ps = psel;
    pw = pwe;
    pa = paddr;
    @(negedge clk_in);
    valid = 1'b0;
    rd = rdata;
    sk = skip;
    check({7'h00, ack}, 8'h01);
    check({7'h00, fault}, {7'h00, f});
    check({7'h00, ps}, {7'h00, !f && !in_reg});
    check({7'h00, pw}, {7'h00, !f && !in_reg && wr_k});
    if (!f && !in_reg)
      check(pa[7:0], da[7:0]);
  endtask

  task automatic ld(input logic [15:0] a, input logic [7:0] exp);
    op(iosad_pkg::OP_LOAD, a, 8'h00, 3'h0, 1'b0);
    check(rd, exp);
  endtask

  initial
  begin
    repeat (12) @(negedge clk_in);
    srst_in = 1'b0;
    foreach (regs[i]) ld(regs[i], 8'h00);
    ld(16'h003C, 8'h00);
    foreach (regs[i]) op(iosad_pkg::OP_STORE, regs[i], vals[i], 3'h0, 1'b0);
    foreach (regs[i]) ld(regs[i], vals[i]);
    op(iosad_pkg::OP_OUT, 16'h002B, 8'h3C, 3'h0, 1'b0);
    ld(16'h004B, 8'h3C);
    op(iosad_pkg::OP_IN, 16'h002A, 8'h00, 3'h0, 1'b0);
    check(rd, 8'hC3);
    op(iosad_pkg::OP_SETBIT, 16'h001E, 8'h00, 3'h0, 1'b0);
    op(iosad_pkg::OP_CLRBIT, 16'h001E, 8'h00, 3'h6, 1'b0);
    ld(16'h003E, 8'h1B);
    op(iosad_pkg::OP_SKIPSET, 16'h001E, 8'h00, 3'h4, 1'b0);
    check({7'h00, sk}, 8'h01);
    op(iosad_pkg::OP_SKIPCLR, 16'h001E, 8'h00, 3'h4, 1'b0);
    check({7'h00, sk}, 8'h00);
    op(iosad_pkg::OP_SKIPCLR, 16'h001E, 8'h00, 3'h2, 1'b0);
    check({7'h00, sk}, 8'h01);
    op(iosad_pkg::OP_SETBIT, 16'h002A, 8'h00, 3'h2, 1'b1);
    ld(16'h004A, 8'hC3);
    op(iosad_pkg::OP_IN, 16'h0040, 8'h00, 3'h0, 1'b1);
    check(rd, 8'h00);
    op(iosad_pkg::OP_LOAD, 16'h001F, 8'h00, 3'h0, 1'b1);
    op(iosad_pkg::OP_LOAD, 16'h0100, 8'h00, 3'h0, 1'b1);
    op(iosad_pkg::OP_STORE, 16'h005F, 8'h77, 3'h0, 1'b0);
    op(iosad_pkg::OP_IN, 16'h003F, 8'h00, 3'h0, 1'b0);
    check(rd, 8'h77);
    op(iosad_pkg::OP_STORE, 16'h0060, 8'h11, 3'h0, 1'b0);
    op(iosad_pkg::OP_STORE, 16'h00FF, 8'h22, 3'h0, 1'b0);
    ld(16'h0060, 8'h11);
    ld(16'h00FF, 8'h22);
    op(iosad_pkg::OP_STORE, 16'h0025, 8'hF0, 3'h0, 1'b0);
    op(iosad_pkg::OP_SETBIT, 16'h0005, 8'h00, 3'h1, 1'b0);
    op(iosad_pkg::OP_CLRBIT, 16'h0005, 8'h00, 3'h7, 1'b0);
    ld(16'h0025, 8'h72);
    op(iosad_pkg::OP_SKIPSET, 16'h0005, 8'h00, 3'h1, 1'b0);
    check({7'h00, sk}, 8'h01);
    @(negedge clk_in);
    flag_set = 8'hFF;
    @(negedge clk_in);
    flag_set = 8'h00;
    check(flags, 8'hFF);
    op(iosad_pkg::OP_STORE, 16'h003C, 8'h0F, 3'h0, 1'b0);
    check(flags, 8'hF0);
    op(iosad_pkg::OP_SETBIT, 16'h001C, 8'h00, 3'h4, 1'b0);
    check(flags, 8'hE0);
    op(iosad_pkg::OP_CLRBIT, 16'h001C, 8'h00, 3'h5, 1'b0);
    check(flags, 8'hE0);
    // A second reset in mid-run must bring the four registers held in the decoder back to zero.
    @(negedge clk_in);
    srst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    srst_in = 1'b0;
    ld(16'h004A, 8'h00);
    ld(16'h003E, 8'h00);
    ld(16'h004B, 8'h00);
    ld(16'h003C, 8'h00);
    end_sim();
  end
endmodule // iosad_decoder_test

/* test/iosad_periph_model.sv */
// Purpose: Peripheral register file behind the decoder's peripheral port.
// Assumes: Writes land at the clock edge that ends the request cycle.
// Notes:   An unselected read shows the inverse of the last value, so it toggles and repeats stale data every second idle cycle.
`timescale 1ns/1ns
module iosad_periph_model (
  input  wire logic        clk_in,
  input  wire logic        sel_in,
  input  wire logic        we_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic [7:0]  wmask_in,
  output logic      [7:0]  rdata_out
);
  logic [7:0] mem [256];
  logic [7:0] last_q = 8'h00;
  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  assign rdata_out = sel_in ? mem[addr_in[7:0]] : ~last_q;
  always @(posedge clk_in)
  begin
    last_q <= rdata_out;
    if (sel_in && we_in)
    begin
      // Only masked bits change, as a real register with bit access would.
      mem[addr_in[7:0]] <= (mem[addr_in[7:0]] & ~wmask_in) | (wdata_in & wmask_in);
    end
  end
endmodule // iosad_periph_model
